// file: common/reset_init_map.vh
`ifndef RESET_INIT_MAP_VH
`define RESET_INIT_MAP_VH
`define CLK_PERIOD_NS      40
`define HARD_MIN_PERIODS   512
`define SOFT_LAG_PERIODS   16
`define CFG_OFF_MAX_NS     4
`define CFG_ON_MIN_PERIODS 1
`define PLL_LOCK_US        100
`define PLL_LOCK_CYCLES    ((`PLL_LOCK_US * 1000) / `CLK_PERIOD_NS)
`define DLL_LOCK_MIN       7680
`define DLL_LOCK_MAX       122880
`define STRAP_SETUP_PERIODS 4
`define RST_SRC_W          3
`define CNT_W              17
`endif

// file: design/reset_init_sequencer.v
`timescale 1ns/1ps
`include "reset_init_map.vh"
module reset_init_sequencer #(
  parameter PLL_CYCLES = `PLL_LOCK_CYCLES,  // pll wait in clk_sys cycles
  parameter DLL_CYCLES = `DLL_LOCK_MAX      // dll wait, worst case ratio
) (
  input  wire                  clk_sys,          // system clock, 25 MHz
  input  wire                  reset,            // sync reset, active high
  input  wire                  clk_en,           // freezes all state when low
  input  wire                  host_mode,        // 1 host, 0 agent
  input  wire                  power_on_reset_n, // power-on reset input
  input  wire                  hard_reset_n_in,  // hard reset pin level
  input  wire                  soft_reset_n_in,  // soft reset pin level
  input  wire                  reset_request,    // internal request to drive reset
  input  wire [`RST_SRC_W-1:0] reset_source_select_in, // strap pins in
  input  wire                  input_clock_divide_cfg_in, // strap pin in
  output reg                   hard_reset_n_out, // always 0 (open drain)
  output reg                   hard_reset_n_oe_n,// low while pulling low
  output reg                   soft_reset_n_out, // always 0 (open drain)
  output reg                   soft_reset_n_oe_n,// low while pulling low
  output reg                   cfg_oe_n,         // low while device drives cfg pins
  output reg                   clock_sel_pci,    // 1 primary clock from pci
  output reg                   sync_div_sel,     // sync period selection
  output reg [`RST_SRC_W-1:0]  reset_source_select, // latched straps
  output reg                   input_clock_divide_cfg, // latched strap
  output reg                   pll_locked,       // pll wait elapsed
  output reg                   dll_locked,       // dll wait elapsed
  output reg                   ready             // sequence done
);
  // sequence overview: power-on holds POR; release walks through the pll
  // and dll waits into RUN. a driven reset (internal request or a board
  // pull seen on either line) goes HARD, then LAG, then repeats the pll
  // and dll waits. the latched straps survive every pass except a new
  // power-on, which recaptures them, or the reset input, which clears them; they are only captured on power-on's rising edge.
  localparam ST_POR   = 3'h0;
  localparam ST_PLL   = 3'h1;
  localparam ST_DLL   = 3'h2;
  localparam ST_RUN   = 3'h3;
  localparam ST_HARD  = 3'h4;
  localparam ST_LAG   = 3'h5;

  reg  [2:0]            state;
  reg  [`CNT_W-1:0]     cnt;
  reg  [2:0]            next_state;
  reg  [`CNT_W-1:0]     next_cnt;
  reg                   por_q;
  reg                   hard_q;
  wire [`RST_SRC_W-1:0] src_held;
  wire                  div_held;
  wire                  por_release = power_on_reset_n & ~por_q;
  // an external pulse shorter than its minimum is still honoured; the
  // board guarantees the minimum, so no filter is applied here
  wire                  ext_reset = ~hard_reset_n_in | ~soft_reset_n_in;

  reset_strap_latch u_strap (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clk_en   (clk_en),
    .capture  (por_release),
    .src_in   (reset_source_select_in),
    .div_in   (input_clock_divide_cfg_in),
    .src_held (src_held),
    .div_held (div_held)
  );

  // edge history of power-on and hard reset levels
  always @(posedge clk_sys) begin
    if (reset) begin
      // idle levels, so leaving reset with power-on high is no false edge
      por_q  <= 1'b1;
      hard_q <= 1'b1;
    end else if (clk_en) begin
      por_q  <= power_on_reset_n;
      hard_q <= hard_reset_n_in;
    end
  end

  // next state and count; power-on low overrides every state
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    if (!power_on_reset_n) begin
      next_state = ST_POR;
      next_cnt   = 17'h00000;
    end else begin
      case (state)
        ST_POR: begin
          next_state = ST_PLL;
          next_cnt   = 17'h00000;
        end
        ST_PLL: begin
          if (cnt >= PLL_CYCLES - 1) begin
            next_state = ST_DLL;
            next_cnt   = 17'h00000;
          end else begin
            next_cnt = cnt + 17'h00001;
          end
        end
        ST_DLL: begin
          // worst case wait covers every ratio down to the minimum
          if (cnt >= DLL_CYCLES - 1) begin
            next_state = ST_RUN;
            next_cnt   = 17'h00000;
          end else begin
            next_cnt = cnt + 17'h00001;
          end
        end
        ST_RUN: begin
          // a line held low by the board counts as a request of our own
          if (reset_request || ext_reset) begin
            next_state = ST_HARD;
            next_cnt   = 17'h00000;
          end
        end
        ST_HARD: begin
          // the line reads low while we pull it, so only the count ends this
          if (cnt >= `HARD_MIN_PERIODS - 1) begin
            next_state = ST_LAG;
            next_cnt   = 17'h00000;
          end else begin
            next_cnt = cnt + 17'h00001;
          end
        end
        ST_LAG: begin
          // lag counts only once the hard line is really high, so a board
          // that keeps holding it stretches the soft pulse as well
          if (!hard_reset_n_in) begin
            next_cnt = 17'h00000;
          end else if (cnt >= `SOFT_LAG_PERIODS - 1) begin
            next_state = ST_PLL;
            next_cnt   = 17'h00000;
          end else begin
            next_cnt = cnt + 17'h00001;
          end
        end
        default: begin
          next_state = ST_POR;
          next_cnt   = 17'h00000;
        end
      endcase
    end
  end

  // state register; clock enable low holds the sequence where it is
  always @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_POR;
      cnt   <= 17'h00000;
    end else if (clk_en) begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // pin drivers; open drain, so the data bit never leaves zero
  always @(posedge clk_sys) begin
    if (reset) begin
      hard_reset_n_out  <= 1'b0;
      hard_reset_n_oe_n <= 1'b1;
      soft_reset_n_out  <= 1'b0;
      soft_reset_n_oe_n <= 1'b1;
      cfg_oe_n          <= 1'b1;
    end else if (clk_en) begin
      hard_reset_n_out  <= 1'b0;
      soft_reset_n_out  <= 1'b0;
      hard_reset_n_oe_n <= ~(state == ST_HARD);
      soft_reset_n_oe_n <= ~(state == ST_HARD || state == ST_LAG);
      // one register stage off the pin; 40 ns clock cannot meet 4 ns, so
      // the pad must gate its driver directly from the hard reset level.
      // never driven during power-on: the board owns the straps then
      cfg_oe_n <= ~(power_on_reset_n && state != ST_POR && hard_reset_n_in
                    && hard_q && state != ST_HARD);
    end
  end

  // clock selection and registered copies of the latched straps
  always @(posedge clk_sys) begin
    if (reset) begin
      clock_sel_pci          <= 1'b0;
      sync_div_sel           <= 1'b0;
      reset_source_select    <= 3'h0;
      input_clock_divide_cfg <= 1'b0;
    end else if (clk_en) begin
      clock_sel_pci          <= ~host_mode;
      sync_div_sel           <= host_mode & div_held;
      reset_source_select    <= src_held;
      input_clock_divide_cfg <= div_held;
    end
  end

  // lock and ready status, one cycle behind the state
  always @(posedge clk_sys) begin
    if (reset) begin
      pll_locked <= 1'b0;
      dll_locked <= 1'b0;
      ready      <= 1'b0;
    end else if (clk_en) begin
      pll_locked <= (state == ST_DLL) || (state == ST_RUN);
      dll_locked <= (state == ST_RUN);
      // a board pull drops ready on the same edge that HARD is entered, one cycle ahead of a request
      ready      <= (state == ST_RUN) && !ext_reset;
    end
  end
endmodule // reset_init_sequencer

// file: design/reset_strap_latch.v
`timescale 1ns/1ps
`include "reset_init_map.vh"
module reset_strap_latch (
  input  wire                  clk_sys,     // system clock
  input  wire                  reset,       // sync reset, active high
  input  wire                  clk_en,      // clock enable
  input  wire                  capture,     // power-on release pulse
  input  wire [`RST_SRC_W-1:0] src_in,      // reset source strap pins
  input  wire                  div_in,      // clock divide strap pin
  output reg  [`RST_SRC_W-1:0] src_held,    // latched source select
  output reg                   div_held     // latched divide strap
);
  // captured once per power-on, kept through hard/soft resets
  always @(posedge clk_sys) begin
    if (reset) begin
      src_held <= 3'h0;
      div_held <= 1'b0;
    end else if (clk_en && capture) begin
      src_held <= src_in;
      div_held <= div_in;
    end
  end
endmodule // reset_strap_latch

// file: testbench/board_supervisor.sv
`timescale 1ns/1ps
module board_supervisor (
  input  wire       clk_sys,   // clock
  input  wire       hard_oe_n, // device pulls hard
  input  wire       soft_oe_n, // device pulls soft
  input  wire       ext_pull,  // board pulls both
  input  wire       por_go,    // start power-on
  input  wire [3:0] strap,     // divide, source
  output wire       hard_pin,  // wired level
  output wire       soft_pin,  // wired level
  output reg        por_n,     // power-on reset
  output reg  [3:0] pins       // strap pins
);
  integer cnt = 0;
  // pull-ups on both lines, wired-and with the device
  assign hard_pin = hard_oe_n & !ext_pull;
  assign soft_pin = soft_oe_n & !ext_pull;
  // straps are garbage except around release, so late sampling shows
  always @(posedge clk_sys) begin
    cnt <= por_go ? 12 : cnt - 1;
    por_n <= !por_go && cnt <= 1;
    pins <= (cnt <= 5 && cnt > -3) ? strap : ~strap;
  end
endmodule // board_supervisor

// file: testbench/reset_init_props.sv
`timescale 1ns/1ps
`include "reset_init_map.vh"
module reset_init_props (
  input wire clk_sys,                // clock
  input wire reset,                  // sync reset
  input wire clk_en,                 // enable
  input wire host_mode,              // mode
  input wire power_on_reset_n,       // por
  input wire hard_reset_n_in,        // hard pin
  input wire hard_reset_n_out,       // hard out
  input wire hard_reset_n_oe_n,      // hard enable
  input wire soft_reset_n_out,       // soft out
  input wire soft_reset_n_oe_n,      // soft enable
  input wire cfg_oe_n,               // cfg enable
  input wire clock_sel_pci,          // clock select
  input wire sync_div_sel,           // sync period select
  input wire input_clock_divide_cfg  // latched strap
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  integer low_cnt = 0;
  integer lag_cnt = 0;
  // pull-low and lag lengths; clk_en stalls only lengthen them
  always @(posedge clk_sys) begin
    low_cnt <= hard_reset_n_oe_n ? 0 : low_cnt + 1;
    lag_cnt <= (hard_reset_n_oe_n && !soft_reset_n_oe_n) ? lag_cnt + 1 : 0;
  end
  a_clock_select: assert property (clk_en |=> clock_sel_pci == !$past(host_mode))
    else $error("clock select wrong");
  a_hard_min: assert property ($rose(hard_reset_n_oe_n) |-> low_cnt >= `HARD_MIN_PERIODS)
    else $error("hard pulse short");
  a_soft_lag: assert property ($rose(soft_reset_n_oe_n) |-> lag_cnt >= `SOFT_LAG_PERIODS)
    else $error("soft release early");
  a_open_drain: assert property (!hard_reset_n_out && !soft_reset_n_out)
    else $error("reset driven high");
  a_cfg_off: assert property (!hard_reset_n_oe_n |-> cfg_oe_n)
    else $error("cfg driven in reset");
  a_cfg_on: assert property ($fell(cfg_oe_n) |-> $past(hard_reset_n_in) && $past(hard_reset_n_in, 2))
    else $error("cfg driven early");
  a_strap_hold: assert property (power_on_reset_n && $past(power_on_reset_n)
    && $past(power_on_reset_n, 2) && $past(power_on_reset_n, 3) |=> $stable(input_clock_divide_cfg))
    else $error("strap changed");
  a_sync_div: assert property (clk_en |=> sync_div_sel == ($past(host_mode) && input_clock_divide_cfg))
    else $error("sync select wrong");
endmodule // reset_init_props
bind reset_init_sequencer reset_init_props u_props (
  .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .host_mode(host_mode),
  .power_on_reset_n(power_on_reset_n), .hard_reset_n_in(hard_reset_n_in),
  .hard_reset_n_out(hard_reset_n_out), .hard_reset_n_oe_n(hard_reset_n_oe_n),
  .soft_reset_n_out(soft_reset_n_out), .soft_reset_n_oe_n(soft_reset_n_oe_n),
  .cfg_oe_n(cfg_oe_n), .clock_sel_pci(clock_sel_pci), .sync_div_sel(sync_div_sel),
  .input_clock_divide_cfg(input_clock_divide_cfg));

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  reg  [4:0] rows [0:3]; // {host, div, source} per row
  reg clk_sys = 0, reset = 1, clk_en = 1, host_mode = 1, reset_request = 0;
  reg ext_pull = 0, por_go = 1;
  reg  [3:0] strap = 4'h0;
  reg  [4:0] r;
  wire hard_pin, soft_pin, por_n, hard_oe_n, soft_oe_n, cfg_oe_n, csel, sdiv, div_q, pll, rdy;
  wire dll;
  wire [3:0] pins;
  wire [2:0] src_q;
  integer fails = 0, checks_done = 0, i, n, m;
  always #20 clk_sys = ~clk_sys;
  board_supervisor u_board_supervisor (.clk_sys(clk_sys), .hard_oe_n(hard_oe_n),
    .soft_oe_n(soft_oe_n), .ext_pull(ext_pull), .por_go(por_go), .strap(strap),
    .hard_pin(hard_pin), .soft_pin(soft_pin), .por_n(por_n), .pins(pins));
  reset_init_sequencer #(.PLL_CYCLES(10), .DLL_CYCLES(20)) u_reset_init_sequencer (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .host_mode(host_mode),
    .power_on_reset_n(por_n), .hard_reset_n_in(hard_pin), .soft_reset_n_in(soft_pin),
    .reset_request(reset_request), .reset_source_select_in(pins[2:0]),
    .input_clock_divide_cfg_in(pins[3]), .hard_reset_n_out(), .hard_reset_n_oe_n(hard_oe_n),
    .soft_reset_n_out(), .soft_reset_n_oe_n(soft_oe_n), .cfg_oe_n(cfg_oe_n),
    .clock_sel_pci(csel), .sync_div_sel(sdiv), .reset_source_select(src_q),
    .input_clock_divide_cfg(div_q), .pll_locked(pll), .dll_locked(dll), .ready(rdy));
  task test_done;
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // a wait that used its whole bound ends the run
  task chk(input ok);
    begin
      checks_done = checks_done + 1;
      if (ok !== 1'b1) begin
        fails = fails + 1;
        $display("MISMATCH %0t check %0d", $time, checks_done);
        if (n >= 2000 || m >= 2000) test_done;
      end
    end
  endtask
  initial begin
    m = 0;
    rows[0] = 5'h1D;
    rows[1] = 5'h0A;
    rows[2] = 5'h13;
    rows[3] = 5'h04;
    repeat (3) @(posedge clk_sys);
    reset <= 0;
    por_go <= 0;
    for (i = 0; i < 4; i = i + 1) begin
      r = rows[i];
      @(posedge clk_sys) {host_mode, strap} <= r;
      por_go <= 1;
      @(posedge clk_sys) por_go <= 0;
      for (n = 0; n < 2000 && (pll || !por_n); n = n + 1) @(negedge clk_sys);
      chk(n < 2000);
      for (n = 0; n < 2000 && !pll; n = n + 1) @(negedge clk_sys);
      for (m = 0; m < 2000 && !rdy; m = m + 1) @(negedge clk_sys);
      chk(n >= 10 && n < 2000);
      chk(m >= 20 && m < 2000 && dll === 1'b1);
      chk(csel === !r[4] && sdiv === (r[4] & r[3]));
      chk(src_q === r[2:0] && div_q === r[3]);
    end
    @(posedge clk_sys) reset_request <= 1;
    @(posedge clk_sys) reset_request <= 0;
    for (n = 0; n < 2000 && hard_oe_n; n = n + 1) @(negedge clk_sys);
    chk(n < 2000);
    @(posedge clk_sys) clk_en <= 0;
    repeat (5) @(posedge clk_sys);
    clk_en <= 1;
    for (n = 7; n < 2000 && !hard_oe_n; n = n + 1) @(negedge clk_sys);
    chk(n >= 512 && n < 2000 && cfg_oe_n === 1'b1 && soft_oe_n === 1'b0);
    for (m = 0; m < 2000 && !soft_oe_n; m = m + 1) @(negedge clk_sys);
    chk(m >= 16 && m < 2000);
    for (m = 0; m < 2000 && !rdy; m = m + 1) @(negedge clk_sys);
    chk(m < 2000 && cfg_oe_n === 1'b0);
    @(posedge clk_sys) ext_pull <= 1;
    repeat (4) @(posedge clk_sys);
    ext_pull <= 0;
    for (n = 0; n < 2000 && hard_oe_n; n = n + 1) @(negedge clk_sys);
    chk(n < 2000);
    for (m = 0; m < 2000 && !rdy; m = m + 1) @(negedge clk_sys);
    chk(m < 2000);
    @(posedge clk_sys) reset <= 1;
    por_go <= 1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) chk(hard_oe_n === 1'b1 && soft_oe_n === 1'b1 && src_q === 3'h0);
    test_done;
  end
endmodule // tb
